// ### afc_pkg.sv
package afc_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned ADC_W         = 12;
   localparam int unsigned NUM_TERM      = 5;
   localparam int unsigned NUM_SET       = 2;
   // filter timing; the accumulator moves 1/16 of the error per tick
   localparam int unsigned FILT_SHIFT    = 4;
   localparam int unsigned FILT_UNIT_NS  = 2_000_000;
   localparam int unsigned FILT_LONG_NS  = 500_000_000;
   localparam int unsigned FILT_UNIT_CYC = FILT_UNIT_NS / (CLK_PERIOD_NS * (1 << FILT_SHIFT));
   localparam int unsigned FILT_LONG_CYC = FILT_LONG_NS / (CLK_PERIOD_NS * (1 << FILT_SHIFT));
   localparam logic [4:0]  FILT_MIN_SET  = 5'h01;
   localparam logic [4:0]  FILT_LONG_SET = 5'h1F;
   localparam logic [4:0]  FILT_RST      = 5'h08;
   // frequency in 0.01 Hz units
   localparam logic [15:0] FREQ_MAX      = 16'h9C40;
   localparam logic [15:0] HYST_CHZ      = 16'h000A;
   localparam logic [16:0] UD_STEP       = 17'h0000A;
   localparam logic [6:0]  RATIO_MAX     = 7'h64;
   localparam logic [10:0] GAIN_MAX      = 11'h7D0;
   localparam logic [10:0] GAIN_RST      = 11'h3E8;
   localparam logic [6:0]  HOLD_FUNC     = 7'h41;
   localparam logic [1:0]  BELOW_ZERO    = 2'h1;
   localparam logic [1:0]  MEM_KEEP      = 2'h1;
   // ratio percent to adc code, about 40.96 per percent
   localparam logic [15:0] RATIO_SCALE   = 16'hA3D7;
   localparam int unsigned RATIO_SHR     = 10;
   // gain in 0.1 percent, divide by 1000 as multiply and shift
   localparam logic [10:0] GAIN_RECIP    = 11'h419;
   localparam int unsigned GAIN_SHR      = 20;
   // register map
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_GAIN     = 8'h04;
   localparam logic [7:0]  ADDR_SET_BASE = 8'h08;
   localparam logic [7:0]  ADDR_SET_STEP = 8'h14;
   localparam logic [7:0]  OFS_START_F   = 8'h00;
   localparam logic [7:0]  OFS_END_F     = 8'h04;
   localparam logic [7:0]  OFS_START_R   = 8'h08;
   localparam logic [7:0]  OFS_END_R     = 8'h0C;
   localparam logic [7:0]  OFS_BELOW     = 8'h10;
   localparam logic [7:0]  ADDR_FUNC     = 8'h30;
   localparam logic [7:0]  ADDR_HELD     = 8'h44;
   localparam logic [7:0]  ADDR_UD_OFS   = 8'h48;
   localparam logic [7:0]  ADDR_STATUS   = 8'h4C;
   // control and status fields
   localparam int unsigned CTRL_FILT_LSB = 0;
   localparam int unsigned CTRL_MEM_LSB  = 8;
   localparam int unsigned CTRL_SRC_BIT  = 12;
   localparam int unsigned STAT_HOLD_BIT = 16;
   localparam int unsigned STAT_RS_BIT   = 17;
   // reset values of the range sets and function codes
   localparam logic [15:0] START_F_RST   = 16'h0000;
   localparam logic [15:0] END_F_RST     = 16'h0000;
   localparam logic [6:0]  START_R_RST   = 7'h00;
   localparam logic [6:0]  END_R_RST     = 7'h64;
   localparam logic [1:0]  BELOW_RST     = 2'h1;
   localparam logic [6:0]  FUNC_RST      = 7'h00;
endpackage

// ### afc_map_if.sv
`timescale 1ns/100ps
// one range mapping request and its result
interface afc_map_if;
   logic [11:0] level;    // conditioned input code
   logic [15:0] start_f;  // start frequency
   logic [15:0] end_f;    // end frequency
   logic [6:0]  start_r;  // start ratio, percent
   logic [6:0]  end_r;    // end ratio, percent
   logic [1:0]  below;    // below-start select
   logic [15:0] freq;     // mapped frequency
   modport mapper (input level, start_f, end_f, start_r, end_r, below, output freq);
   modport user   (output level, start_f, end_f, start_r, end_r, below, input freq);
endinterface

// ### afc_filter.sv
`timescale 1ns/100ps
module afc_filter (
   input  wire logic        clk,       // system clock
   input  wire logic        reset_n,   // async reset
   input  wire logic        ce,        // clock enable
   input  wire logic [4:0]  setting,   // filter setting
   input  wire logic [31:0] unit_cyc,  // tick cycles per setting step
   input  wire logic [31:0] long_cyc,  // tick cycles for the long filter
   input  wire logic [11:0] din,       // raw level
   output logic      [11:0] dout       // filtered level
);
   import afc_pkg::*;

   logic [31:0] cnt_reg;
   logic [31:0] period;
   logic [15:0] acc_reg;
   logic signed [16:0] err;

   // tick period scales with the setting, or is long_cyc at the long setting, so one shift serves every constant
   // time constant steps
   always_comb begin
      if (setting == FILT_LONG_SET) begin
         period = long_cyc;
      end else begin
         period = unit_cyc * 32'(setting);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg <= 32'h00000000;
      end else if (ce) begin
         if (cnt_reg + 32'h00000001 >= period) begin
            cnt_reg <= 32'h00000000;
         end else begin
            cnt_reg <= cnt_reg + 32'h00000001;
         end
      end
   end

   // first-order step, four fraction bits kept against drift
   assign err = $signed({1'b0, din, 4'h0}) - $signed({1'b0, acc_reg});

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_reg <= 16'h0000;
      end else if (ce && cnt_reg + 32'h00000001 >= period) begin
         acc_reg <= 16'($signed({1'b0, acc_reg}) + (err >>> FILT_SHIFT));
      end
   end

   assign dout = acc_reg[15:4];
endmodule

// ### afc_mapper.sv
`timescale 1ns/100ps
module afc_mapper (
   afc_map_if.mapper m  // mapping request and result
);
   import afc_pkg::*;

   logic [11:0]        thr_lo;
   logic [11:0]        thr_hi;
   logic signed [31:0] span_f;
   logic signed [31:0] prod;
   logic [31:0]        q;

   // ratio percent to adc code thresholds
   assign thr_lo = 12'((32'(m.start_r) * 32'(RATIO_SCALE)) >> RATIO_SHR);
   assign thr_hi = 12'((32'(m.end_r) * 32'(RATIO_SCALE)) >> RATIO_SHR);
   assign span_f = $signed(32'(m.end_f)) - $signed(32'(m.start_f));
   assign prod   = span_f * $signed(32'(m.level - thr_lo));

   // combinational divide keeps the path short in cycles; it is a long
   // timing path, acceptable for a slow control loop
   always_comb begin
      q = 32'h00000000;
      if (m.level < thr_lo) begin
         m.freq = (m.below == BELOW_ZERO) ? 16'h0000 : m.start_f;
      end else if (m.level >= thr_hi) begin
         m.freq = m.end_f;
      end else begin
         q      = 32'(prod / $signed(32'(thr_hi - thr_lo)));
         m.freq = 16'(32'(m.start_f) + q);
      end
   end
endmodule

// ### afc_top.sv
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module afc_top #(
   parameter int unsigned FILT_UNIT_CYC_P = afc_pkg::FILT_UNIT_CYC,  // filter tick per step
   parameter int unsigned FILT_LONG_CYC_P = afc_pkg::FILT_LONG_CYC   // long filter tick
) (
   input  wire logic        clk,                    // 100 MHz system clock
   input  wire logic        reset_n,                // async reset, active low
   input  wire logic        ce,                     // clock enable, freezes all state
   input  wire logic        psel,                   // apb select
   input  wire logic        penable,                // apb enable
   input  wire logic        pwrite,                 // apb direction
   input  wire logic [7:0]  paddr,                  // apb byte address
   input  wire logic [31:0] pwdata,                 // apb write data
   output logic      [31:0] prdata,                 // apb read data
   output logic             pready,                 // apb ready
   output logic             pslverr,                // apb error, unmapped
   input  wire logic [11:0] terminal_analog_input,  // terminal adc code
   input  wire logic [11:0] panel_knob_input,       // knob adc code
   input  wire logic [4:0]  input_terminal,         // multifunction inputs
   input  wire logic        reset_input_terminal,   // reset terminal, high = reset
   input  wire logic        up_input_terminal,      // up command
   input  wire logic        down_input_terminal,    // down command
   output logic      [15:0] target_freq,            // target frequency, 0.01 Hz
   output logic             hold_active             // hold in force
);
   import afc_pkg::*;

   // pin synchronisers
   logic [11:0] term_s1;
   logic [11:0] term_s2;
   logic [11:0] knob_s1;
   logic [11:0] knob_s2;
   logic [4:0]  in_s1;
   logic [4:0]  in_s2;
   logic [2:0]  ctl_s1;
   logic [2:0]  ctl_s2;
   logic [1:0]  ud_prev_reg;
   // registers
   logic [4:0]  filt_set_reg;
   logic [1:0]  mem_sel_reg;
   logic        src_sel_reg;
   logic [10:0] gain_reg;
   logic [15:0] start_f_reg [NUM_SET];
   logic [15:0] end_f_reg   [NUM_SET];
   logic [6:0]  start_r_reg [NUM_SET];
   logic [6:0]  end_r_reg   [NUM_SET];
   logic [1:0]  below_reg   [NUM_SET];
   logic [6:0]  func_reg    [NUM_TERM];
   logic [11:0] held_reg;
   logic signed [16:0] ofs_reg;
   logic        hold_prev_reg;
   logic [15:0] target_reg;
   logic [31:0] prdata_reg;
   // datapath
   logic [4:0]  func_hit;
   logic        hold_act;
   logic        rs_act;
   logic        up_pulse;
   logic        dn_pulse;
   logic        wr;
   logic        rd_setup;
   logic        hit;
   logic [11:0] src_level;
   logic [11:0] filt_level;
   logic [11:0] gained;
   logic [33:0] gain_prod;
   logic signed [18:0] cand_s;
   logic [15:0] cand;
   logic [15:0] diff;
   logic [31:0] rd_mux;

   afc_map_if mif ();

   // two flops on every pin before use
   // a code caught mid-change may be off for one sample; the filter smooths it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         term_s1 <= 12'h000;
         term_s2 <= 12'h000;
         knob_s1 <= 12'h000;
         knob_s2 <= 12'h000;
         in_s1   <= 5'h00;
         in_s2   <= 5'h00;
         ctl_s1  <= 3'h0;
         ctl_s2  <= 3'h0;
      end else if (ce) begin
         term_s1 <= terminal_analog_input;
         term_s2 <= term_s1;
         knob_s1 <= panel_knob_input;
         knob_s2 <= knob_s1;
         in_s1   <= input_terminal;
         in_s2   <= in_s1;
         ctl_s1  <= {down_input_terminal, up_input_terminal, reset_input_terminal};
         ctl_s2  <= ctl_s1;
      end
   end

   // up/down edge detect on the settled stage only
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ud_prev_reg <= 2'h0;
      end else if (ce) begin
         ud_prev_reg <= ctl_s2[2:1];
      end
   end

   // pulses last one cycle; up and down together are ignored further on
   assign rs_act   = ctl_s2[0];
   assign up_pulse = ctl_s2[1] & ~ud_prev_reg[0];
   assign dn_pulse = ctl_s2[2] & ~ud_prev_reg[1];

   // pready tied high, so read data must stand when penable rises
   // apb decode; no wait states
   assign wr       = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~hit;

   always_comb begin
      hit    = 1'b1;
      rd_mux = 32'h00000000;
      case (paddr)
         ADDR_CTRL:   rd_mux = {19'h00000, src_sel_reg, 2'h0, mem_sel_reg, 3'h0, filt_set_reg};
         ADDR_GAIN:   rd_mux = {21'h000000, gain_reg};
         ADDR_HELD:   rd_mux = {20'h00000, held_reg};
         ADDR_UD_OFS: rd_mux = {{15{ofs_reg[16]}}, ofs_reg};
         ADDR_STATUS: rd_mux = {14'h0000, rs_act, hold_act, target_reg};
         default: begin
            hit = 1'b0;
            for (int s = 0; s < NUM_SET; s++) begin
               if (paddr == ADDR_SET_BASE + 8'(s) * ADDR_SET_STEP + OFS_START_F) begin
                  hit    = 1'b1;
                  rd_mux = {16'h0000, start_f_reg[s]};
               end
               if (paddr == ADDR_SET_BASE + 8'(s) * ADDR_SET_STEP + OFS_END_F) begin
                  hit    = 1'b1;
                  rd_mux = {16'h0000, end_f_reg[s]};
               end
               if (paddr == ADDR_SET_BASE + 8'(s) * ADDR_SET_STEP + OFS_START_R) begin
                  hit    = 1'b1;
                  rd_mux = {25'h0000000, start_r_reg[s]};
               end
               if (paddr == ADDR_SET_BASE + 8'(s) * ADDR_SET_STEP + OFS_END_R) begin
                  hit    = 1'b1;
                  rd_mux = {25'h0000000, end_r_reg[s]};
               end
               if (paddr == ADDR_SET_BASE + 8'(s) * ADDR_SET_STEP + OFS_BELOW) begin
                  hit    = 1'b1;
                  rd_mux = {30'h00000000, below_reg[s]};
               end
            end
            for (int t = 0; t < NUM_TERM; t++) begin
               if (paddr == ADDR_FUNC + 8'(t) * 8'h04) begin
                  hit    = 1'b1;
                  rd_mux = {25'h0000000, func_reg[t]};
               end
            end
         end
      endcase
   end

   // read data captured in the setup cycle, presented in the access cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata_reg <= 32'h00000000;
      end else if (ce && rd_setup) begin
         prdata_reg <= rd_mux;
      end
   end

   assign prdata = prdata_reg;

   // control and gain; out-of-range writes are pulled into range
   // filter setting 0 has no meaning, so it reads back as 1
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         filt_set_reg <= FILT_RST;
         mem_sel_reg  <= 2'h0;
         src_sel_reg  <= 1'b0;
         gain_reg     <= GAIN_RST;
      end else if (ce && wr) begin
         if (paddr == ADDR_CTRL) begin
            filt_set_reg <= (pwdata[CTRL_FILT_LSB +: 5] < FILT_MIN_SET) ? FILT_MIN_SET
                            : pwdata[CTRL_FILT_LSB +: 5];
            mem_sel_reg  <= pwdata[CTRL_MEM_LSB +: 2];
            src_sel_reg  <= pwdata[CTRL_SRC_BIT];
         end
         if (paddr == ADDR_GAIN) begin
            gain_reg <= (pwdata > 32'(GAIN_MAX)) ? GAIN_MAX : pwdata[10:0];
         end
      end
   end

   // one range set per source
   for (genvar s = 0; s < NUM_SET; s++) begin : g_set
      localparam logic [7:0] BASE = ADDR_SET_BASE + 8'(s) * ADDR_SET_STEP;
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            start_f_reg[s] <= START_F_RST;
            end_f_reg[s]   <= END_F_RST;
            start_r_reg[s] <= START_R_RST;
            end_r_reg[s]   <= END_R_RST;
            below_reg[s]   <= BELOW_RST;
         end else if (ce && wr) begin
            if (paddr == BASE + OFS_START_F) begin
               start_f_reg[s] <= (pwdata > 32'(FREQ_MAX)) ? FREQ_MAX : pwdata[15:0];
            end
            if (paddr == BASE + OFS_END_F) begin
               end_f_reg[s] <= (pwdata > 32'(FREQ_MAX)) ? FREQ_MAX : pwdata[15:0];
            end
            // start ratio is held against the stored end ratio; widen the end first
            // ratio ordering
            if (paddr == BASE + OFS_START_R) begin
               start_r_reg[s] <= (pwdata > 32'(end_r_reg[s])) ? end_r_reg[s] : pwdata[6:0];
            end
            if (paddr == BASE + OFS_END_R) begin
               end_r_reg[s] <= (pwdata > 32'(RATIO_MAX)) ? RATIO_MAX
                               : (pwdata < 32'(start_r_reg[s])) ? start_r_reg[s] : pwdata[6:0];
            end
            if (paddr == BASE + OFS_BELOW) begin
               below_reg[s] <= pwdata[1:0];
            end
         end
      end
   end

   // terminal function codes and hold match
   for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            func_reg[t] <= FUNC_RST;
         end else if (ce && wr && paddr == ADDR_FUNC + 8'(t) * 8'h04) begin
            func_reg[t] <= pwdata[6:0];
         end
      end
      assign func_hit[t] = in_s2[t] & (func_reg[t] == HOLD_FUNC);
   end

   // several terminals may carry the hold code; any one of them holds
   assign hold_act    = |func_hit;
   assign hold_active = hold_act;

   assign src_level = src_sel_reg ? knob_s2 : term_s2;

   // a source switch lets the filter settle from the old level, no jump
   afc_filter i_afc_filter (
      .clk      (clk),
      .reset_n  (reset_n),
      .ce       (ce),
      .setting  (filt_set_reg),
      .unit_cyc (FILT_UNIT_CYC_P),
      .long_cyc (FILT_LONG_CYC_P),
      .din      (src_level),
      .dout     (filt_level)
   );

   // saturate instead of wrap so a high gain never folds to a low level
   // gain scaling
   assign gain_prod = 34'(filt_level) * 34'(gain_reg) * 34'(GAIN_RECIP);
   assign gained    = (gain_prod >> GAIN_SHR > 34'h000000FFF) ? 12'hFFF : 12'(gain_prod >> GAIN_SHR);

   // held value and up/down offset; software may restore both after power-up
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         held_reg      <= 12'h000;
         ofs_reg       <= 17'h00000;
         // starts high, but hold_act is 0 out of reset (func_reg resets to 0), so the first hold edge still loads held_reg
         hold_prev_reg <= 1'b1;
      end else if (ce) begin
         hold_prev_reg <= hold_act;
         if (wr && paddr == ADDR_HELD) begin
            held_reg <= pwdata[11:0];
         end
         if (wr && paddr == ADDR_UD_OFS) begin
            ofs_reg <= pwdata[16:0];
         end
         if (!rs_act && hold_act && !hold_prev_reg) begin
            held_reg <= gained;
         end
         if (!rs_act && hold_act) begin
            // offset stops near full scale so repeated steps cannot wrap sign
            // up/down while held
            if (up_pulse && !dn_pulse && ofs_reg < $signed({1'b0, FREQ_MAX})) begin
               ofs_reg <= ofs_reg + $signed(UD_STEP);
            end else if (dn_pulse && !up_pulse && ofs_reg > -$signed({1'b0, FREQ_MAX})) begin
               ofs_reg <= ofs_reg - $signed(UD_STEP);
            end
         end else if (!hold_act && hold_prev_reg && mem_sel_reg != MEM_KEEP) begin
            ofs_reg <= 17'h00000;
         end
      end
   end

   // active set applied
   // held_reg loads at the first hold edge, so that cycle still uses the live level
   assign mif.level   = (hold_act && hold_prev_reg) ? held_reg : gained;
   assign mif.start_f = start_f_reg[src_sel_reg];
   assign mif.end_f   = end_f_reg[src_sel_reg];
   assign mif.start_r = start_r_reg[src_sel_reg];
   assign mif.end_r   = end_r_reg[src_sel_reg];
   assign mif.below   = below_reg[src_sel_reg];

   afc_mapper i_afc_mapper (
      .m (mif)
   );

   // offset counts only under hold, so a kept offset waits for the next hold
   // offset applied to mapped value
   assign cand_s = $signed({3'h0, mif.freq}) + (hold_act ? 19'(ofs_reg) : 19'h00000);
   assign cand   = (cand_s < 0) ? 16'h0000 : (cand_s > $signed({3'h0, FREQ_MAX})) ? FREQ_MAX
                   : cand_s[15:0];
   assign diff   = (cand > target_reg) ? cand - target_reg : target_reg - cand;

   // output register; reset terminal forces zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         target_reg <= 16'h0000;
      end else if (ce) begin
         if (rs_act) begin
            target_reg <= 16'h0000;
         end else if (filt_set_reg == FILT_LONG_SET) begin
            // compared with the last output, so slow drift still moves it in steps
            // hysteresis band
            if (diff > HYST_CHZ) begin
               target_reg <= cand;
            end
         end else begin
            target_reg <= cand;
         end
      end
   end

   assign target_freq = target_reg;
endmodule

// ### afc_motor_model.sv
`timescale 1ns/100ps
// downstream consumer of the commanded frequency
module afc_motor_model (
   input  wire logic        clk,          // system clock
   input  wire logic        reset_n,      // async reset
   input  wire logic [15:0] target_freq,  // command in
   output logic      [15:0] applied_freq  // frequency applied
);
   // one cycle late, as a real speed loop would take it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         applied_freq <= 16'h0000;
      end else begin
         applied_freq <= target_freq;
      end
   end
endmodule

// ### afc_top_monitor.sv
`timescale 1ns/100ps
module afc_top_monitor #(
   parameter int unsigned FILT_UNIT_CYC_P = 2,  // filter step
   parameter int unsigned FILT_LONG_CYC_P = 8   // long filter
) (
   input wire logic        clk,                    // clock
   input wire logic        reset_n,                // reset
   input wire logic        ce,                     // enable
   input wire logic        psel,                   // apb
   input wire logic        penable,                // apb
   input wire logic        pwrite,                 // apb
   input wire logic [7:0]  paddr,                  // apb
   input wire logic [31:0] pwdata,                 // apb
   input wire logic [31:0] prdata,                 // apb
   input wire logic        pready,                 // apb
   input wire logic        pslverr,                // apb
   input wire logic [11:0] terminal_analog_input,  // adc
   input wire logic [11:0] panel_knob_input,       // adc
   input wire logic [4:0]  input_terminal,         // pins
   input wire logic        reset_input_terminal,   // pin
   input wire logic        up_input_terminal,      // pin
   input wire logic        down_input_terminal,    // pin
   input wire logic [15:0] target_freq,            // result
   input wire logic        hold_active             // hold
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // hold on and nothing asking for a change
   sequence s_quiet;
      hold_active && ce && !psel && !reset_input_terminal && !up_input_terminal && !down_input_terminal;
   endsequence
   // reset terminal on long enough to pass the synchronizer
   sequence s_term_reset;
      (reset_input_terminal && ce) [*5];
   endsequence
   AST_HOLD_FREEZE: assert property (s_quiet [*6] |=> $stable(target_freq))
      else $error("target moved during quiet hold");
   AST_TERM_RESET_ZERO: assert property (s_term_reset |-> target_freq == 16'h0000)
      else $error("target not zero under reset terminal");
   AST_HOLD_NEEDS_PIN: assert property (hold_active && $past(ce) && $past(ce, 2) |-> $past(input_terminal, 2) != 5'h00)
      else $error("hold without any input pin on");
   AST_NO_PIN_NO_HOLD: assert property ($past(ce) && $past(ce, 2) && $past(input_terminal, 2) == 5'h00 |-> !hold_active)
      else $error("hold with all input pins off");
   AST_FREQ_CEILING: assert property (target_freq <= afc_pkg::FREQ_MAX)
      else $error("target above ceiling");
   AST_ERR_IN_ACCESS: assert property (pslverr |-> psel && penable)
      else $error("slave error outside access");
   AST_RDATA_HELD: assert property (psel && penable && ce |=> $stable(prdata))
      else $error("read data moved after access");
   AST_NO_WAIT: assert property (pready)
      else $error("ready dropped");
endmodule

bind afc_top afc_top_monitor #(.FILT_UNIT_CYC_P(FILT_UNIT_CYC_P), .FILT_LONG_CYC_P(FILT_LONG_CYC_P)) i_afc_top_monitor (
   .clk, .reset_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .terminal_analog_input, .panel_knob_input, .input_terminal, .reset_input_terminal,
   .up_input_terminal, .down_input_terminal, .target_freq, .hold_active);

// ### analog_freq_command_path_bench.sv
`timescale 1ns/100ps
module analog_freq_command_path_bench;
   logic        clk = 1'b0, reset_n = 1'b0, ce = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic [11:0] terminal_analog_input = 12'h000, panel_knob_input = 12'h000;
   logic [4:0]  input_terminal = 5'h00;
   logic        reset_input_terminal = 1'b0, up_input_terminal = 1'b0, down_input_terminal = 1'b0;
   logic        pready, pslverr, hold_active, rerr;
   logic [15:0] target_freq, applied_freq;
   int          errors = 0, check_count = 0, cyc = 0;
   // short filter ticks keep settling within a few hundred cycles
   afc_top #(.FILT_UNIT_CYC_P(2), .FILT_LONG_CYC_P(8)) i_afc_top (.clk, .reset_n, .ce, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .terminal_analog_input, .panel_knob_input,
      .input_terminal, .reset_input_terminal, .up_input_terminal, .down_input_terminal, .target_freq,
      .hold_active);
   afc_motor_model i_afc_motor_model (.clk, .reset_n, .target_freq, .applied_freq);
   always #5 clk = ~clk;
   // cycle ceiling cuts a hung wait short
   always @(posedge clk) begin
      cyc++;
      if (cyc > 40000) begin
         errors++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("errors=%0d checks=%0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // one apb transfer, request held until pready is seen
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask
   // bounded wait for the applied frequency, then compare
   task automatic tgt(input logic [15:0] e);
      for (int i = 0; i < 900 && applied_freq !== e; i++) @(posedge clk);
      chk({16'h0000, applied_freq}, {16'h0000, e});
   endtask
   // one up or down step; pins stay low long enough for the edge detector
   task automatic pulse(input logic up);
      up_input_terminal <= up;
      down_input_terminal <= ~up;
      repeat (3) @(posedge clk);
      up_input_terminal <= 1'b0;
      down_input_terminal <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd(8'h04, 32'h3E8);
      rd(8'h14, 32'h64);
      rd(8'h18, 32'h1);
      rd(8'h50, 32'h0);
      chk(rerr, 1'b1);
      // terminal range 10 to 50 Hz across 20..80 percent
      bus(1'b1, 8'h00, 32'h1);
      bus(1'b1, 8'h08, 32'h3E8);
      bus(1'b1, 8'h0C, 32'h1388);
      bus(1'b1, 8'h14, 32'h50);
      bus(1'b1, 8'h10, 32'h14);
      terminal_analog_input <= 12'hFFF;
      tgt(16'h1388);
      terminal_analog_input <= 12'h000;
      tgt(16'h0000);
      bus(1'b1, 8'h18, 32'h0);
      tgt(16'h03E8);
      // knob set only counts while the knob is the source
      bus(1'b1, 8'h1C, 32'h7D0);
      bus(1'b1, 8'h24, 32'h32);
      bus(1'b1, 8'h2C, 32'h0);
      bus(1'b1, 8'h00, 32'h1001);
      tgt(16'h07D0);
      bus(1'b1, 8'h00, 32'h1);
      terminal_analog_input <= 12'hFFF;
      tgt(16'h1388);
      // hold on pin 2, then the analog input falls away
      bus(1'b1, 8'h38, 32'h41);
      input_terminal <= 5'h04;
      repeat (4) @(posedge clk);
      chk(hold_active, 1'b1);
      @(posedge clk);
      chk({16'h0000, applied_freq}, 32'h1388);
      terminal_analog_input <= 12'h000;
      repeat (600) @(posedge clk);
      tgt(16'h1388);
      pulse(1'b1);
      tgt(16'h1392);
      rd(8'h48, 32'hA);
      reset_input_terminal <= 1'b1;
      repeat (8) @(posedge clk);
      tgt(16'h0000);
      reset_input_terminal <= 1'b0;
      tgt(16'h1392);
      input_terminal <= 5'h00;
      repeat (4) @(posedge clk);
      rd(8'h48, 32'h0);
      // memory kept: the offset outlives the hold
      bus(1'b1, 8'h00, 32'h101);
      input_terminal <= 5'h04;
      repeat (4) @(posedge clk);
      pulse(1'b1);
      pulse(1'b1);
      tgt(16'h03FC);
      pulse(1'b0);
      tgt(16'h03F2);
      input_terminal <= 5'h00;
      repeat (4) @(posedge clk);
      rd(8'h48, 32'hA);
      // out-of-range writes come back clamped
      bus(1'b1, 8'h10, 32'h5A);
      rd(8'h10, 32'h50);
      bus(1'b1, 8'h14, 32'h78);
      rd(8'h14, 32'h64);
      bus(1'b1, 8'h0C, 32'hFFFF);
      rd(8'h0C, 32'h9C40);
      bus(1'b1, 8'h04, 32'hBB8);
      rd(8'h04, 32'h7D0);
      // long filter: a step inside the 0.1 Hz band is held back
      bus(1'b1, 8'h00, 32'h1F);
      bus(1'b1, 8'h08, 32'h3ED);
      repeat (4) @(posedge clk);
      chk({16'h0000, applied_freq}, 32'h3E8);
      bus(1'b1, 8'h08, 32'h3F3);
      tgt(16'h03F3);
      // writes with the clock enable low are lost
      ce <= 1'b0;
      bus(1'b1, 8'h08, 32'h7D0);
      ce <= 1'b1;
      rd(8'h08, 32'h3F3);
      stop_test();
   end
endmodule
